/* ppc_pkg.sv */
package ppc_pkg;
    localparam logic [3:0] PAGE_CFG = 4'hf;
    localparam logic [3:0] PAGE_LATCH = 4'h0;
    localparam logic [7:0] ADDR_P2_DRIVE = 8'h9b;
    localparam logic [7:0] ADDR_P2_SKIP = 8'hc7;
    localparam logic [7:0] ADDR_PORT3_LATCH = 8'he1;
    localparam logic [7:0] ADDR_PORT3_INMODE = 8'hef;
    localparam logic [7:0] ADDR_PORT3_OUTMODE = 8'hdf;
    localparam logic [7:0] RST_P2_DRIVE = 8'h00;
    localparam logic [7:0] RST_P2_SKIP = 8'h00;
    localparam logic [7:0] RST_PORT3_LATCH = 8'hff;
    localparam logic [7:0] RST_PORT3_INMODE = 8'hff;
    localparam logic [7:0] RST_PORT3_OUTMODE = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // Register bus request from the core.
    typedef struct packed {
        logic [3:0] page;
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } ppc_req_t;

    // All state of the port block.
    typedef struct packed {
        logic [7:0] p2_skip;
        logic [7:0] p2_drive;
        logic [7:0] port3_latch;
        logic [7:0] port3_inmode;
        logic [7:0] port3_outmode;
        logic [7:0] rdata;
        logic rvalid;
        logic [7:0] pin_o;
        logic [7:0] pin_oe;
    } ppc_state_t;
endpackage

/* ppc_port.sv */
`timescale 1ns/1ps
// Port 2 configuration bits and port 3 latch and modes behind the paged register bus.
// Every output is a flop of the state struct, so pads never see a decode glitch.
module ppc_port (
    input wire logic sys_clk_i, // 40 MHz core clock.
    input wire logic rst_b_i, // Synchronous reset, active low.
    input wire ppc_pkg::ppc_req_t req_i, // Register bus request.
    output logic [7:0] rdata_o, // Read data, valid with rvalid_o.
    output logic rvalid_o, // One-cycle pulse marking read data.
    input wire logic [7:0] port3_pin_i, // Sampled level at each port 3 pin.
    output logic [7:0] port3_pin_o, // Port 3 pin output level.
    output logic [7:0] port3_pin_oe_o, // Port 3 pin output enable, high drives.
    output logic [7:0] p2_skip_o, // Port 2 crossbar skip, 1 skips pin.
    output logic [7:0] p2_drive_high_o, // Port 2 high drive select.
    output logic [7:0] port3_digital_o // Port 3 digital mode, 0 is analog.
);

    // Registered state and the copy that the combinational process fills.
    ppc_pkg::ppc_state_t st;
    ppc_pkg::ppc_state_t next_st;

    // Address match on page and address together.
    // The page keeps the latch apart from configuration registers that share the space.
    function automatic logic hit(input ppc_pkg::ppc_req_t r, input logic [3:0] pg,
                                 input logic [7:0] ad);
        hit = (r.page == pg) && (r.addr == ad);
    endfunction

    // New latch value: digital pins take the written bit, analog pins keep theirs.
    function automatic logic [7:0] merge_latch(input logic [7:0] wd,
                                               input logic [7:0] old,
                                               input logic [7:0] dig);
        merge_latch = (wd & dig) | (old & ~dig);
    endfunction

    // Pad enable on a digital pin: low always drives, high drives only in push-pull.
    // An analog pin is never driven, so the pad stays free for the analog path.
    function automatic logic [7:0] pad_enable(input logic [7:0] lat,
                                              input logic [7:0] dig,
                                              input logic [7:0] pp);
        pad_enable = dig & (~lat | pp);
    endfunction

    // Register writes, read mux and pad drive for the next cycle.
    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;

        // Writes; an address that matches nothing is ignored.
        if (req_i.wr) begin
            if (hit(req_i, ppc_pkg::PAGE_CFG, ppc_pkg::ADDR_P2_SKIP)) begin
                next_st.p2_skip = req_i.wdata;
            end else if (hit(req_i, ppc_pkg::PAGE_CFG, ppc_pkg::ADDR_P2_DRIVE)) begin
                next_st.p2_drive = req_i.wdata;
            end else if (hit(req_i, ppc_pkg::PAGE_LATCH, ppc_pkg::ADDR_PORT3_LATCH)) begin
                // Analog pins keep their old latch bit.
                next_st.port3_latch = merge_latch(req_i.wdata, st.port3_latch,
                                                  st.port3_inmode);
            end else if (hit(req_i, ppc_pkg::PAGE_CFG, ppc_pkg::ADDR_PORT3_INMODE)) begin
                next_st.port3_inmode = req_i.wdata;
            end else if (hit(req_i, ppc_pkg::PAGE_CFG, ppc_pkg::ADDR_PORT3_OUTMODE)) begin
                next_st.port3_outmode = req_i.wdata;
            end
        end

        // Reads look at the current state, so a write in the same cycle shows next time.
        if (req_i.rd) begin
            next_st.rvalid = 1'b1;
            if (hit(req_i, ppc_pkg::PAGE_CFG, ppc_pkg::ADDR_P2_SKIP)) begin
                next_st.rdata = st.p2_skip;
            end else if (hit(req_i, ppc_pkg::PAGE_CFG, ppc_pkg::ADDR_P2_DRIVE)) begin
                next_st.rdata = st.p2_drive;
            end else if (hit(req_i, ppc_pkg::PAGE_LATCH, ppc_pkg::ADDR_PORT3_LATCH)) begin
                // Pin level, not latch; analog pins read as zero.
                next_st.rdata = port3_pin_i & st.port3_inmode;
            end else if (hit(req_i, ppc_pkg::PAGE_CFG, ppc_pkg::ADDR_PORT3_INMODE)) begin
                next_st.rdata = st.port3_inmode;
            end else if (hit(req_i, ppc_pkg::PAGE_CFG, ppc_pkg::ADDR_PORT3_OUTMODE)) begin
                next_st.rdata = st.port3_outmode;
            end else begin
                next_st.rdata = ppc_pkg::RD_UNMAPPED; // Unmapped reads return zero.
            end
        end

        // Pad drive follows the new latch and modes, so it changes with the register.
        next_st.pin_o = next_st.port3_latch;
        next_st.pin_oe = pad_enable(next_st.port3_latch, next_st.port3_inmode,
                                    next_st.port3_outmode);

        // Reset wins over any request in the same cycle.
        if (!rst_b_i) begin
            next_st.p2_skip = ppc_pkg::RST_P2_SKIP;
            next_st.p2_drive = ppc_pkg::RST_P2_DRIVE;
            next_st.port3_latch = ppc_pkg::RST_PORT3_LATCH;
            next_st.port3_inmode = ppc_pkg::RST_PORT3_INMODE;
            next_st.port3_outmode = ppc_pkg::RST_PORT3_OUTMODE;
            next_st.rdata = ppc_pkg::RD_UNMAPPED;
            next_st.rvalid = 1'b0;
            next_st.pin_o = ppc_pkg::RST_PORT3_LATCH;
            next_st.pin_oe = 8'h00; // Open-drain high floats after reset.
        end
    end

    // Single state register; reset is folded into next_st.
    always_ff @(posedge sys_clk_i) begin
        st <= next_st;
    end

    // Outputs straight from the state flops.
    assign rdata_o = st.rdata;
    assign rvalid_o = st.rvalid;
    assign port3_pin_o = st.pin_o;
    assign port3_pin_oe_o = st.pin_oe;
    assign p2_skip_o = st.p2_skip;
    assign p2_drive_high_o = st.p2_drive;
    assign port3_digital_o = st.port3_inmode;

    // Reset values of skip, drive, input mode and latch, the pads and the read strobe.
    a_skip_reset: assert property (@(posedge sys_clk_i) !rst_b_i |=> p2_skip_o == 8'h00)
        else $error("skip not cleared by reset");

    a_latch_reset: assert property (@(posedge sys_clk_i) !rst_b_i |=> st.port3_latch == 8'hff
        && port3_digital_o == 8'hff && p2_drive_high_o == 8'h00)
        else $error("reset values wrong");

    a_pad_reset: assert property (@(posedge sys_clk_i) !rst_b_i |=> port3_pin_oe_o == 8'h00
        && port3_pin_o == 8'hff && !rvalid_o)
        else $error("pads not released by reset");

    // Writes land one edge after they are taken: on the outputs, or in st for the output mode.
    a_drive_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        req_i.wr && req_i.page == 4'hf && req_i.addr == 8'h9b
        |=> p2_drive_high_o == $past(req_i.wdata))
        else $error("drive write not stored");

    a_skip_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        req_i.wr && req_i.page == 4'hf && req_i.addr == 8'hc7
        |=> p2_skip_o == $past(req_i.wdata))
        else $error("skip write not stored");

    a_inmode_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        req_i.wr && req_i.page == 4'hf && req_i.addr == 8'hef
        |=> port3_digital_o == $past(req_i.wdata))
        else $error("input mode write not stored");

    a_outmode_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        req_i.wr && req_i.page == 4'hf && req_i.addr == 8'hdf
        |=> st.port3_outmode == $past(req_i.wdata))
        else $error("output mode write not stored");

    // Latch read gives the pin level, masked to the digital pins.
    a_latch_read: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        req_i.rd && req_i.page == 4'h0 && req_i.addr == 8'he1
        |=> rvalid_o && rdata_o == ($past(port3_pin_i) & $past(st.port3_inmode)))
        else $error("latch read not pin level");

    // The read strobe is a single-cycle pulse; without a read it stays low.
    a_rvalid_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !req_i.rd |=> !rvalid_o)
        else $error("read valid without read");

    a_unmapped_read: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        req_i.rd && req_i.page == 4'hf && req_i.addr == 8'h00
        |=> rvalid_o && rdata_o == 8'h00)
        else $error("unmapped read not zero");

    // Analog pins keep their latch bit across a latch write.
    a_analog_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        req_i.wr && req_i.page == 4'h0 && req_i.addr == 8'he1
        |=> ((st.port3_latch ^ $past(st.port3_latch)) & ~$past(st.port3_inmode)) == 8'h00)
        else $error("analog pin latch changed");

    // Pad drive against latch and modes.
    a_low_drives: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        ##1 ((~st.port3_latch & st.port3_inmode & ~port3_pin_oe_o) == 8'h00))
        else $error("low latch not driven");

    a_open_float: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        ##1 ((st.port3_latch & ~st.port3_outmode & port3_pin_oe_o) == 8'h00))
        else $error("open-drain high driven");

    a_pushpull_high: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        ##1 ((st.port3_latch & st.port3_outmode & port3_digital_o
        & ~port3_pin_oe_o) == 8'h00))
        else $error("push-pull high not driven");

    a_analog_free: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        ##1 ((~port3_digital_o & port3_pin_oe_o) == 8'h00))
        else $error("analog pin driven");

    a_pin_level: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        ##1 (port3_pin_o == st.port3_latch))
        else $error("pin level differs from latch");

    // Main scenarios worth seeing at least once.
    c_latch_write: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        req_i.wr && req_i.page == 4'h0 && req_i.addr == 8'he1);

    c_pushpull_high: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        |(st.port3_latch & st.port3_outmode & port3_pin_oe_o));

    c_analog_pin: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        port3_digital_o != 8'hff);

    c_write_read: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        req_i.wr && req_i.rd);

    c_skip_set: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        |p2_skip_o);

    // Limitation: the drive and skip bits are handed on as flags only;
    // the pad strength itself and the crossbar's choice of pins live outside this block.
    // Trade-off: reads always return the registered value one cycle later,
    // which costs a cycle of latency but keeps the read data free of pin glitches.
    // A read of the latch while a write to it is taken sees the pins before the write.
    // Bits of an analog pin read as zero, so software cannot mistake noise for a level.

endmodule

/* ppc_pin_model.sv */
`timescale 1ns/1ps
// Port 3 pads: a driven pin shows the block's level, a released one the outside level.
module ppc_pin_model (
    input wire logic [7:0] pin_o_i, // Block output level.
    input wire logic [7:0] pin_oe_i, // Block output enable, high drives.
    input wire logic [7:0] ext_i, // Pull-up or external driver level.
    output logic [7:0] level_o // Resolved level at each pin.
);
    // Open-drain high floats, so the pull or the outside wins there.
    assign level_o = (pin_o_i & pin_oe_i) | (ext_i & ~pin_oe_i);
endmodule

/* port2_port3_pin_config_tb.sv */
`timescale 1ns/1ps
module port2_port3_pin_config_tb;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    ppc_pkg::ppc_req_t req = '0;
    logic [7:0] ext = 8'hff;
    logic [7:0] rdata, p3o, p3oe, p3lv, skip, drv, dig;
    logic rvalid;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    // Clock at 40 MHz; the cycle ceiling stops a hung run.
    always #12.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            test_done();
        end
    end
    ppc_port i_ppc_port (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .req_i(req),
        .rdata_o(rdata), .rvalid_o(rvalid), .port3_pin_i(p3lv), .port3_pin_o(p3o),
        .port3_pin_oe_o(p3oe), .p2_skip_o(skip), .p2_drive_high_o(drv),
        .port3_digital_o(dig));
    ppc_pin_model i_ppc_pin_model (.pin_o_i(p3o), .pin_oe_i(p3oe), .ext_i(ext),
        .level_o(p3lv));
    // Compare and count; an unknown never matches.
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // One bus cycle; returns at the falling edge where the answer stands.
    task automatic acc(input logic [3:0] pg, input logic [7:0] ad, input logic w,
        input logic [7:0] wd);
        @(negedge sys_clk_i);
        req = '{page: pg, addr: ad, wr: w, rd: ~w, wdata: wd};
        @(negedge sys_clk_i);
        req = '0;
        if (!w) chk({7'h00, rvalid}, 8'h01);
    endtask
    task automatic t_reset();
        acc(4'hf, 8'h9b, 1'b0, 8'h00); chk(rdata, 8'h00);
        acc(4'hf, 8'hc7, 1'b0, 8'h00); chk(rdata, 8'h00);
        acc(4'hf, 8'hef, 1'b0, 8'h00); chk(rdata, 8'hff);
        acc(4'h0, 8'he1, 1'b0, 8'h00); chk(rdata, 8'hff);
        chk(p3o, 8'hff);
        chk(p3oe, 8'h00);
    endtask
    task automatic t_cfg();
        acc(4'hf, 8'h9b, 1'b1, 8'h5a); chk(drv, 8'h5a);
        acc(4'hf, 8'hc7, 1'b1, 8'ha5); chk(skip, 8'ha5);
        acc(4'h0, 8'h9b, 1'b1, 8'hff); chk(drv, 8'h5a);
        acc(4'hf, 8'h9b, 1'b0, 8'h00); chk(rdata, 8'h5a);
        acc(4'hf, 8'hc7, 1'b0, 8'h00); chk(rdata, 8'ha5);
    endtask
    task automatic t_latch();
        ext = 8'h55;
        acc(4'hf, 8'hdf, 1'b1, 8'h0f);
        acc(4'h0, 8'he1, 1'b1, 8'h3c); chk(p3o, 8'h3c);
        chk(p3oe, 8'hcf);
        acc(4'h0, 8'he1, 1'b0, 8'h00); chk(rdata, (8'h3c & 8'hcf) | (ext & 8'h30));
    endtask
    // Low nibble turned analog: writes there are dropped and reads come back 0.
    task automatic t_analog();
        acc(4'hf, 8'hef, 1'b1, 8'hf0); chk(dig, 8'hf0);
        acc(4'h0, 8'he1, 1'b1, 8'h00); chk(p3o, 8'h0c);
        chk(p3oe, 8'hf0);
        acc(4'h0, 8'he1, 1'b0, 8'h00); chk(rdata, 8'h00);
        acc(4'hf, 8'h00, 1'b0, 8'h00); chk(rdata, 8'h00);
    endtask
    // Write and read of one register in one cycle: the read sees the old value.
    task automatic t_both();
        @(negedge sys_clk_i);
        req = '{page: 4'hf, addr: 8'h9b, wr: 1'b1, rd: 1'b1, wdata: 8'h33};
        @(negedge sys_clk_i);
        req = '0;
        chk(rdata, 8'h5a);
        chk(drv, 8'h33);
        acc(4'hf, 8'hdf, 1'b0, 8'h00); chk(rdata, 8'h0f);
        @(negedge sys_clk_i);
        chk({7'h00, rvalid}, 8'h00);
    endtask
    // Reset in mid-run restores every register and releases the pads.
    task automatic t_rst_mid();
        rst_b_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        rst_b_i = 1'b1;
        chk(drv, 8'h00);
        chk(skip, 8'h00);
        chk(dig, 8'hff);
        chk(p3o, 8'hff);
        chk(p3oe, 8'h00);
        acc(4'hf, 8'hdf, 1'b0, 8'h00); chk(rdata, 8'h00);
    endtask
    task automatic test_done();
        if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge sys_clk_i);
        rst_b_i = 1'b1;
        t_reset();
        t_cfg();
        t_latch();
        t_analog();
        t_both();
        t_rst_mid();
        test_done();
    end
endmodule
